// File: rtl/usfc_pkg.sv
package usfc_pkg;
  // register byte addresses (low address byte)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD_LOW = 8'h04;
  localparam logic [7:0] ADDR_BAUD_HIGH = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int BAUD_W = 12;
  localparam int LOW_W = 8;
  localparam int HIGH_W = BAUD_W - LOW_W;
  localparam int CHAR_W = 9;
  localparam logic [2:0] CSZ_NINE = 3'h7;
  localparam logic [2:0] CSZ_EIGHT = 3'h3;
  localparam logic [3:0] BITS_MIN = 4'h5;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam logic [4:0] SAMP_NORMAL = 5'h10;
  localparam logic [4:0] SAMP_DOUBLE = 5'h08;
  localparam logic [4:0] SAMP_SYNC = 5'h02;
  localparam logic [8:0] ALL_ONES = 9'h1FF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // control register layout, bit 0 is sync_mode_select
  typedef struct packed {
    logic rx_enable;
    logic tx_enable;
    logic transmit_ninth_bit;
    logic stop_bit_select;
    logic [1:0] parity_mode_field;
    logic [2:0] character_size_field;
    logic sync_clock_polarity;
    logic transfer_clock_pin_direction;
    logic double_speed_bit;
    logic sync_mode_select;
  } usfc_ctrl_s;
  localparam int CTRL_W = $bits(usfc_ctrl_s);

  // status register layout, bit 0 is tx_pending
  typedef struct packed {
    logic parity_error;
    logic frame_error_flag;
    logic rx_valid;
    logic tx_busy;
    logic tx_pending;
  } usfc_stat_s;
  localparam int STAT_W = $bits(usfc_stat_s);

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h3,
    TX_PARITY = 3'h2,
    TX_STOP1 = 3'h6,
    TX_STOP2 = 3'h7
  } usfc_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_PARITY = 3'h2,
    RX_STOP = 3'h6
  } usfc_rx_e;

  typedef struct packed {
    usfc_ctrl_s ctrl;
    logic [BAUD_W-1:0] divisor;
    logic [BAUD_W-1:0] bcnt;
    logic x1;
    logic x2;
    logic x3;
    logic xtog;
    usfc_tx_e tst;
    logic [4:0] tpre;
    logic [3:0] tidx;
    logic [CHAR_W-1:0] tsh;
    logic [CHAR_W-1:0] thold;
    logic tpend;
    logic tpar;
    logic txd;
    usfc_rx_e rst;
    logic [4:0] rph;
    logic [3:0] ridx;
    logic [CHAR_W-1:0] rsh;
    logic rpar;
    logic rpe;
    logic [CHAR_W-1:0] rdata;
    logic rvalid;
    logic fe;
    logic pe;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] hrdata;
  } usfc_state_s;
endpackage

// File: rtl/usfc_core.sv
// How it works
// - four clock modes, sync_mode_select picks framing
// - in sync mode pin direction picks master/slave
// - transfer clock pin idle in async modes
// - baud counter reloads at zero and low write
// - one baud tick per zero, divisor plus one
// - transmitter divides ticks by 16, 8 or 2
// - receiver phase machine with 16 or 8 states, async only
// - 12-bit divisor from high and low registers
// - double speed ignored when synchronous
// - double speed receiver uses 8 samples
// - slave clock synchronised then edge detected
// - sync sample edge opposite to change edge
// - polarity bit picks change and sample edges
// - 5-9 data, none/even/odd parity, 1-2 stops
// - start, data lsb first, parity, stops
// - next frame back to back or idle high
// - one shared frame format for both directions
// - only first stop bit checked for frame error
// - even parity xor of data, odd inverted
// - size, parity and stop select fields
// - size 7 means nine bits, ninth from control
// - surplus high transmit bits ignored
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module usfc_core
  import usfc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  input wire logic transfer_clock_pin_i,
  output logic transfer_clock_pin_o,
  output logic transfer_clock_pin_oe
);

  usfc_state_s s_reg;
  usfc_state_s s_next;

  function automatic logic [3:0] data_bits(input logic [2:0] csz);
    if (csz == CSZ_NINE) begin
      data_bits = BITS_NINE;
    end else if (csz <= CSZ_EIGHT) begin
      data_bits = BITS_MIN + {1'b0, csz};
    end else begin
      // reserved sizes fall back to eight bits
      data_bits = BITS_EIGHT;
    end
  endfunction

  function automatic logic [8:0] char_mask(input logic [3:0] nb);
    char_mask = ALL_ONES >> (BITS_NINE - nb);
  endfunction

  function automatic logic parity_of(input logic [8:0] d,
                                     input logic [3:0] nb,
                                     input logic odd);
    parity_of = (^(d & char_mask(nb))) ^ odd;
  endfunction

  function automatic logic [4:0] samples(input usfc_ctrl_s c);
    if (c.sync_mode_select) begin
      samples = SAMP_SYNC;
    end else if (c.double_speed_bit) begin
      samples = SAMP_DOUBLE;
    end else begin
      samples = SAMP_NORMAL;
    end
  endfunction

  always_comb begin
    logic sync;
    logic master;
    logic slave;
    logic tick;
    logic rise;
    logic fall;
    logic chg;
    logic smp;
    logic tbit;
    logic rsmp;
    logic fin;
    logic par_en;
    logic odd;
    logic addr_ph;
    logic [3:0] nb;
    logic [4:0] nsamp;
    logic [31:0] rd;
    sync = 1'b0;
    master = 1'b0;
    slave = 1'b0;
    tick = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    chg = 1'b0;
    smp = 1'b0;
    tbit = 1'b0;
    rsmp = 1'b0;
    fin = 1'b0;
    par_en = 1'b0;
    odd = 1'b0;
    addr_ph = 1'b0;
    nb = '0;
    nsamp = '0;
    rd = '0;
    s_next = s_reg;

    // mode decode
    sync = s_reg.ctrl.sync_mode_select;
    master = sync & s_reg.ctrl.transfer_clock_pin_direction;
    slave = sync & ~s_reg.ctrl.transfer_clock_pin_direction;
    nsamp = samples(s_reg.ctrl);
    nb = data_bits(s_reg.ctrl.character_size_field);
    par_en = s_reg.ctrl.parity_mode_field[1];
    odd = (s_reg.ctrl.parity_mode_field == PAR_ODD);

    // baud generator
    tick = (s_reg.bcnt == '0);
    if (tick) begin
      s_next.bcnt = s_reg.divisor;
    end else begin
      s_next.bcnt = s_reg.bcnt - 1'b1;
    end

    // slave clock: x1 feeds only x2, edges taken from x2/x3
    s_next.x1 = transfer_clock_pin_i;
    s_next.x2 = s_reg.x1;
    s_next.x3 = s_reg.x2;
    if (master && tick) begin
      s_next.xtog = ~s_reg.xtog;
    end else if (!master) begin
      s_next.xtog = 1'b0;
    end
    if (master) begin
      rise = tick & ~s_reg.xtog;
      fall = tick & s_reg.xtog;
    end else if (slave) begin
      rise = s_reg.x2 & ~s_reg.x3;
      fall = ~s_reg.x2 & s_reg.x3;
    end
    chg = s_reg.ctrl.sync_clock_polarity ? fall : rise;
    smp = s_reg.ctrl.sync_clock_polarity ? rise : fall;

    // transmitter bit clock
    if (sync) begin
      tbit = chg;
    end else if (tick) begin
      if (s_reg.tpre >= nsamp - 1'b1) begin
        s_next.tpre = '0;
        tbit = 1'b1;
      end else begin
        s_next.tpre = s_reg.tpre + 1'b1;
      end
    end

    // transmitter
    if (tbit) begin
      case (s_reg.tst)
        TX_IDLE: begin
          s_next.txd = 1'b1;
          fin = 1'b1;
        end
        TX_START: begin
          s_next.txd = s_reg.tsh[0];
          s_next.tsh = s_reg.tsh >> 1;
          s_next.tidx = 4'h1;
          s_next.tst = TX_DATA;
        end
        TX_DATA: begin
          if (s_reg.tidx == nb) begin
            if (par_en) begin
              s_next.txd = s_reg.tpar;
              s_next.tst = TX_PARITY;
            end else begin
              s_next.txd = 1'b1;
              s_next.tst = TX_STOP1;
            end
          end else begin
            s_next.txd = s_reg.tsh[0];
            s_next.tsh = s_reg.tsh >> 1;
            s_next.tidx = s_reg.tidx + 1'b1;
          end
        end
        TX_PARITY: begin
          s_next.txd = 1'b1;
          s_next.tst = TX_STOP1;
        end
        TX_STOP1: begin
          if (s_reg.ctrl.stop_bit_select) begin
            s_next.txd = 1'b1;
            s_next.tst = TX_STOP2;
          end else begin
            fin = 1'b1;
          end
        end
        TX_STOP2: begin
          fin = 1'b1;
        end
        default: begin
          s_next.tst = TX_IDLE;
          s_next.txd = 1'b1;
        end
      endcase
      if (fin) begin
        // a pending character starts with no gap, else line idles high
        if (s_reg.tpend && s_reg.ctrl.tx_enable) begin
          s_next.tsh = s_reg.thold & char_mask(nb);
          s_next.tpar = parity_of(s_reg.thold, nb, odd);
          s_next.tpend = 1'b0;
          s_next.txd = 1'b0;
          s_next.tst = TX_START;
        end else begin
          s_next.txd = 1'b1;
          s_next.tst = TX_IDLE;
        end
      end
    end

    // bus: address phase, read data registered for the data phase
    addr_ph = hsel & htrans[1] & hready;
    s_next.ph_wr = addr_ph & hwrite;
    s_next.ph_addr = haddr[7:0];
    if (addr_ph && !hwrite) begin
      case (haddr[7:0])
        ADDR_CTRL: rd = {{(32-CTRL_W){1'b0}}, s_reg.ctrl};
        ADDR_BAUD_LOW: rd = {24'h0, s_reg.divisor[LOW_W-1:0]};
        ADDR_BAUD_HIGH: rd = {28'h0, s_reg.divisor[BAUD_W-1:LOW_W]};
        ADDR_DATA: begin
          rd = {23'h0, s_reg.rdata};
          s_next.rvalid = 1'b0;
        end
        ADDR_STATUS: begin
          rd = {{(32-STAT_W){1'b0}}, s_reg.pe, s_reg.fe, s_reg.rvalid,
                (s_reg.tst != TX_IDLE), s_reg.tpend};
        end
        default: rd = '0;
      endcase
      s_next.hrdata = rd;
    end
    if (s_reg.ph_wr) begin
      case (s_reg.ph_addr)
        ADDR_CTRL: s_next.ctrl = usfc_ctrl_s'(hwdata[CTRL_W-1:0]);
        ADDR_BAUD_LOW: begin
          s_next.divisor[LOW_W-1:0] = hwdata[LOW_W-1:0];
          s_next.bcnt = {s_reg.divisor[BAUD_W-1:LOW_W],
                         hwdata[LOW_W-1:0]};
        end
        ADDR_BAUD_HIGH: begin
          s_next.divisor[BAUD_W-1:LOW_W] = hwdata[HIGH_W-1:0];
        end
        ADDR_DATA: begin
          if (s_reg.ctrl.tx_enable) begin
            s_next.thold = {s_reg.ctrl.transmit_ninth_bit,
                            hwdata[LOW_W-1:0]};
            s_next.tpend = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // receiver sample strobe: phase counter when async, edge when sync
    if (sync) begin
      rsmp = smp;
    end else if (tick && s_reg.rst != RX_IDLE) begin
      if (s_reg.rph >= nsamp - 1'b1) begin
        s_next.rph = '0;
      end else begin
        s_next.rph = s_reg.rph + 1'b1;
      end
      rsmp = (s_reg.rph == (nsamp >> 1));
    end

    // receiver; a completed frame wins over a same-cycle data read
    case (s_reg.rst)
      RX_IDLE: begin
        s_next.rph = '0;
        s_next.ridx = '0;
        s_next.rpar = 1'b0;
        if (s_reg.ctrl.rx_enable && !serial_receive_pin) begin
          if (sync && smp) begin
            s_next.rst = RX_DATA;
          end else if (!sync && tick) begin
            s_next.rph = 5'h01;
            s_next.rst = RX_START;
          end
        end
      end
      RX_START: begin
        if (rsmp) begin
          // a start bit gone high at mid-bit is a glitch
          s_next.rst = serial_receive_pin ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rsmp) begin
          s_next.rsh = {serial_receive_pin, s_reg.rsh[8:1]};
          s_next.rpar = s_reg.rpar ^ serial_receive_pin;
          s_next.ridx = s_reg.ridx + 1'b1;
          if (s_reg.ridx + 1'b1 == nb) begin
            s_next.rst = par_en ? RX_PARITY : RX_STOP;
          end
        end
      end
      RX_PARITY: begin
        if (rsmp) begin
          s_next.rpe = s_reg.rpar ^ serial_receive_pin ^ odd;
          s_next.rst = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rsmp) begin
          // second stop bit is never looked at
          s_next.fe = ~serial_receive_pin;
          s_next.pe = par_en & s_reg.rpe;
          s_next.rpe = 1'b0;
          s_next.rdata = s_reg.rsh >> (BITS_NINE - nb);
          s_next.rvalid = 1'b1;
          s_next.rst = RX_IDLE;
        end
      end
      default: s_next.rst = RX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.txd <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.hrdata;
  assign serial_transmit_pin = s_reg.txd;
  // async modes leave the pin undriven
  assign transfer_clock_pin_o = s_reg.xtog;
  assign transfer_clock_pin_oe = s_reg.ctrl.sync_mode_select &
    s_reg.ctrl.transfer_clock_pin_direction;

endmodule
`default_nettype wire

// File: sim/usfc_core_checker.sv
`timescale 1ns/10ps
`default_nettype none
module usfc_core_checker
  import usfc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic serial_receive_pin,
  input wire logic serial_transmit_pin,
  input wire logic transfer_clock_pin_i,
  input wire logic transfer_clock_pin_o,
  input wire logic transfer_clock_pin_oe
);
  logic wr_reg;
  logic [7:0] wa_reg;
  logic [12:0] ctl_reg;
  logic [7:0] lo_reg;
  logic mst;
  logic rd;
  assign mst = ctl_reg[0] & ctl_reg[2];
  assign rd = hsel & htrans[1] & hready & !hwrite;
  // shadow of control and low divisor, written at end of data phase
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_reg <= 1'b0;
      ctl_reg <= '0;
      lo_reg <= '0;
    end else begin
      wr_reg <= hsel & htrans[1] & hready & hwrite;
      if (wr_reg && wa_reg == ADDR_CTRL) ctl_reg <= hwdata[12:0];
      if (wr_reg && wa_reg == ADDR_BAUD_LOW) lo_reg <= hwdata[7:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    wa_reg <= haddr[7:0];
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_rd(a);
    rd && haddr[7:0] == a;
  endsequence
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or not okay");
  property p_unmap;
    rd && haddr[7:0] > ADDR_STATUS |=> hrdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_lo;
    s_rd(ADDR_BAUD_LOW) |=> hrdata == {24'h0, lo_reg};
  endproperty
  a_lo: assert property (p_lo) else $error("low divisor readback");
  property p_hi;
    s_rd(ADDR_BAUD_HIGH) |=> hrdata[31:4] == 28'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("high divisor width");
  property p_hold;
    !rd |=> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data not held");
  property p_oe_on;
    mst && $past(mst) |-> transfer_clock_pin_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("master idle");
  property p_oe_off;
    !mst && !$past(mst) |-> !transfer_clock_pin_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven");
  property p_quiet;
    !ctl_reg[0] && !$past(ctl_reg[0]) |-> !$rose(transfer_clock_pin_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("clock in async");
  property p_edge;
    mst && $past(mst) && $changed(serial_transmit_pin) |->
      $changed(transfer_clock_pin_o) && transfer_clock_pin_o != ctl_reg[3];
  endproperty
  a_edge: assert property (p_edge) else $error("data edge");
  property p_start;
    $fell(serial_transmit_pin) && !ctl_reg[0] |-> !serial_transmit_pin [*8];
  endproperty
  a_start: assert property (p_start) else $error("short start");
endmodule
bind usfc_core usfc_core_checker i_usfc_core_checker (.ref_clk, .rstn,
  .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
  .hresp, .hrdata, .serial_receive_pin, .serial_transmit_pin,
  .transfer_clock_pin_i, .transfer_clock_pin_o, .transfer_clock_pin_oe);
`default_nettype wire

// File: sim/usfc_peer.sv
`timescale 1ns/10ps
`default_nettype none
module usfc_peer (
  input wire logic ref_clk,
  input wire logic txd,
  output logic rxd,
  output logic xck
);
  // no slave clock offered, so the quarter-rate limit holds
  assign xck = 1'b0;
  initial rxd = 1'b1;
  // start bit at f[0], then data lsb first as the frame is built
  task automatic send(input logic [12:0] f, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (bc) @(posedge ref_clk);
    end
    rxd <= 1'b1;
  endtask
  task automatic catch_start();
    int t;
    t = 0;
    while (txd !== 1'b0 && t < 1000) begin
      @(posedge ref_clk);
      t++;
    end
  endtask
  // samples mid-bit; returns at the middle of bit n
  task automatic recv(input int n, input int bc, output logic [12:0] f);
    f = '0;
    repeat (bc / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (bc) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// File: sim/usfc_core_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module usfc_core_tb_top
  import usfc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rv, c;
  logic hreadyout, hresp, rxd, txd, xck_i, xck_o, xck_oe, x;
  logic [12:0] got, f;
  logic [8:0] d, dm;
  int nb, n, bc, k;
  int fails = 0;
  int checks = 0;
  logic [31:0] fmt[5] = '{32'h1B00, 32'h19B2, 32'h1C70, 32'h19A0, 32'h1B10};
  logic [7:0] dat[5] = '{8'hF5, 8'hA6, 8'h3C, 8'h80, 8'h2A};
  logic [31:0] ee[3] = '{32'h10, 32'h08, 32'h00};
  always #2 ref_clk = ~ref_clk;
  usfc_core i_usfc_core (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .serial_receive_pin(rxd),
    .serial_transmit_pin(txd), .transfer_clock_pin_i(xck_i),
    .transfer_clock_pin_o(xck_o), .transfer_clock_pin_oe(xck_oe));
  usfc_peer i_usfc_peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd),
    .xck(xck_i));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    r = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    xfer(1'b0, a, 32'h0, rv);
    chk(rv & m, e);
  endtask
  function automatic logic [12:0] frm(input logic [8:0] dd, input int b,
      input logic [1:0] pm, input logic s2);
    logic [12:0] r;
    logic p;
    int j;
    r = '0;
    p = pm[0];
    for (j = 0; j < b; j++) begin
      r[j + 1] = dd[j];
      p = p ^ dd[j];
    end
    j = b + 1;
    if (pm[1]) begin
      r[j] = p;
      j++;
    end
    r[j] = 1'b1;
    r[j + 1] = s2;
    return r;
  endfunction
  task automatic setup(input int i);
    c = fmt[i];
    nb = (c[6:4] == CSZ_NINE) ? 9 : c[6:4] + 5;
    n = 2 + nb + c[8] + c[9];
    bc = (c[1] ? 8 : 16) * (i % 2 + 1);
    d = {c[10], dat[i]};
    dm = d & (ALL_ONES >> (9 - nb));
    xfer(1'b1, ADDR_CTRL, c, rv);
    xfer(1'b1, ADDR_BAUD_LOW, i % 2, rv);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd_chk(ADDR_CTRL, '1, 32'h0);
    rd_chk(ADDR_STATUS, '1, 32'h0);
    rd_chk(8'h14, '1, 32'h0);
    xfer(1'b1, ADDR_BAUD_HIGH, '1, rv);
    xfer(1'b1, ADDR_BAUD_LOW, '1, rv);
    rd_chk(ADDR_BAUD_HIGH, '1, 32'hF);
    rd_chk(ADDR_BAUD_LOW, '1, 32'hFF);
    xfer(1'b1, ADDR_BAUD_HIGH, 32'h0, rv);
    for (int i = 0; i < 5; i++) begin
      setup(i);
      xfer(1'b1, ADDR_DATA, {24'h0, dat[i]}, rv);
      i_usfc_peer.catch_start();
      // second write lands while the first frame is on the line
      fork
        i_usfc_peer.recv(n, bc, got);
        xfer(1'b1, ADDR_DATA, {24'h0, dat[i]}, rv);
      join
      chk(got, frm(dm, nb, c[8:7], c[9]));
      chk(txd, 1'b0);
      // second frame has taken the pending character: busy, none pending
      rd_chk(ADDR_STATUS, 32'h3, 32'h2);
      repeat (n * bc) @(posedge ref_clk);
    end
    for (int i = 0; i < 5; i++) begin
      setup(i);
      i_usfc_peer.send(frm(dm, nb, c[8:7], c[9]), n, bc);
      rd_chk(ADDR_STATUS, 32'h1C, 32'h04);
      rd_chk(ADDR_DATA, '1, {23'h0, dm});
    end
    setup(0);
    for (int e = 0; e < 3; e++) begin
      f = frm(dm, nb, c[8:7], c[9]);
      f[6 + e] = ~f[6 + e];
      i_usfc_peer.send(f, n, bc);
      rd_chk(ADDR_STATUS, 32'h18, ee[e]);
      // a low second stop is taken as a new start; let that frame drain
      repeat (n * bc) @(posedge ref_clk);
    end
    xfer(1'b1, ADDR_BAUD_LOW, 32'h1, rv);
    for (int p = 0; p < 2; p++) begin
      xfer(1'b1, ADDR_CTRL, 32'h805 | (p << 3), rv);
      xfer(1'b1, ADDR_DATA, 32'h5A, rv);
      repeat (60) @(posedge ref_clk);
      chk(xck_oe, 1'b1);
    end
    x = xck_o;
    k = 0;
    repeat (40) begin
      @(posedge ref_clk);
      k += xck_o & ~x;
      x = xck_o;
    end
    chk(k, 10);
    xfer(1'b1, ADDR_CTRL, 32'h1, rv);
    repeat (3) @(posedge ref_clk);
    chk(xck_oe, 1'b0);
    xfer(1'b1, ADDR_CTRL, 32'h0, rv);
    repeat (3) @(posedge ref_clk);
    chk(xck_oe, 1'b0);
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
